/* design/cpmc_pkg.sv */
// constants, types and decode helpers for the charging port mode control
package cpmc_pkg;

  // ***************************************************************
  // modes and states
  // ***************************************************************
  typedef enum logic [2:0]
  {
    CPMC_M_DCP_LO = 3'h0,
    CPMC_M_DCP = 3'h1,
    CPMC_M_SDP = 3'h2,
    CPMC_M_CLIENT = 3'h4,
    CPMC_M_SDP_LO = 3'h6,
    CPMC_M_CDP = 3'h7
  } cpmc_mode_e;

  typedef enum logic [1:0]
  {
    CPMC_ST_RUN = 2'h0,
    CPMC_ST_DISCH = 2'h1,
    CPMC_ST_THERM = 2'h2
  } cpmc_st_e;

  // ***************************************************************
  // register map
  // ***************************************************************
  localparam logic [7:0] CPMC_OFS_CTRL = 8'h00;
  localparam logic [7:0] CPMC_OFS_STATE = 8'h04;
  localparam logic [7:0] CPMC_OFS_IRQ_STAT = 8'h08;
  localparam logic [7:0] CPMC_OFS_IRQ_MASK = 8'h0c;
  localparam logic [31:0] CPMC_CTRL_RST = 32'h0000_0000;
  localparam logic [3:0] CPMC_MASK_RST = 4'h0;
  localparam int CPMC_CTRL_SW_OFF = 0;
  localparam int CPMC_IRQ_THERM = 0;
  localparam int CPMC_IRQ_MODE = 1;
  localparam int CPMC_IRQ_STATUS = 2;
  localparam int CPMC_IRQ_DISCH = 3;
  localparam int CPMC_IRQ_W = 4;

  // ***************************************************************
  // timing
  // ***************************************************************
  localparam int CPMC_CLK_HZ = 10_000_000;
  localparam int CPMC_T_STATUS_ON_MS = 210;
  localparam int CPMC_T_STATUS_OFF_MS = 3000;
  localparam int CPMC_T_DISCH_MS = 10;
  localparam int CPMC_STATUS_ON_CYC =
    CPMC_T_STATUS_ON_MS * (CPMC_CLK_HZ / 1000);
  localparam int CPMC_STATUS_OFF_CYC =
    CPMC_T_STATUS_OFF_MS * (CPMC_CLK_HZ / 1000);
  localparam int CPMC_DISCH_CYC = CPMC_T_DISCH_MS * (CPMC_CLK_HZ / 1000);
  localparam int CPMC_CNT_W = 32;

  // ***************************************************************
  // helpers
  // ***************************************************************
  function automatic cpmc_mode_e cpmc_decode(input logic [2:0] pins);
    cpmc_mode_e m;
    m = CPMC_M_CLIENT;
    case (pins)
      3'h0: m = CPMC_M_DCP_LO;
      3'h1: m = CPMC_M_DCP;
      3'h2, 3'h3: m = CPMC_M_SDP;
      3'h4, 3'h5: m = CPMC_M_CLIENT;
      3'h6: m = CPMC_M_SDP_LO;
      3'h7: m = CPMC_M_CDP;
      default: m = CPMC_M_CLIENT;
    endcase
    return m;
  endfunction

  function automatic logic cpmc_exempt(input cpmc_mode_e a,
                                       input cpmc_mode_e b);
    return ((a == CPMC_M_DCP_LO) && (b == CPMC_M_DCP)) ||
           ((a == CPMC_M_DCP) && (b == CPMC_M_DCP_LO)) ||
           ((a == CPMC_M_SDP_LO) && (b == CPMC_M_CDP)) ||
           ((a == CPMC_M_CDP) && (b == CPMC_M_SDP_LO));
  endfunction

  function automatic logic cpmc_is_high(input cpmc_mode_e m);
    return (m == CPMC_M_DCP) || (m == CPMC_M_CDP);
  endfunction

endpackage

/* design/cpmc_qual.sv */
// qualification timer: done rises once cond has held for COUNT cycles
`timescale 1ns/1ps
module cpmc_qual #(
  parameter int COUNT = 16,
  parameter int W = 32
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic cond,
  output logic done
);

  logic [W-1:0] cnt;

  // ***************************************************************
  // counter, cleared whenever cond drops
  // ***************************************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt <= '0;
      done <= 1'b0;
    end
    else if (!cond)
    begin
      cnt <= '0;
      done <= 1'b0;
    end
    else if (cnt >= W'(COUNT - 1))
      done <= 1'b1;
    else
      cnt <= cnt + W'(1);
  end

endmodule

/* design/cpmc_top.sv */
// charging port mode, discharge, thermal and reporting control
// Functional notes
// - decode the three select pins into six charging modes
// - follow the select pins continuously, no other trigger
// - high limit in 001/111, low in 000/01X/110, none in client
// - status reports only in 001 and 111, else held deasserted
// - no overcurrent fault in 000 and 110; other faults still reported
// - client mode: switch off, data bypass, status/fault/sense off
// - change between 000 and 001 needs no output discharge
// - change between 110 and 111 needs no output discharge
// - in 111 run the automatic port type switching
// - while limiting, the limiting thermal trip turns switch off
// - while not limiting, the normal thermal trip turns switch off
// - restart when trip clears, cycling until fault is gone
// - fault output asserted throughout thermal shutdown
// - overcurrent gives constant current; only thermal trip shuts down
// - discharge turns switch off, drains output, then switch back on unless the new mode is client
// - status asserts after 210 ms above, clears after 3 s below
`timescale 1ns/1ps
module cpmc_top
#(
  parameter int STATUS_ON_CYC = cpmc_pkg::CPMC_STATUS_ON_CYC,
  parameter int STATUS_OFF_CYC = cpmc_pkg::CPMC_STATUS_OFF_CYC,
  parameter int DISCH_CYC = cpmc_pkg::CPMC_DISCH_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic mode_select_msb,
  input wire logic mode_select_mid,
  input wire logic mode_select_lsb,
  input wire logic overcurrent,
  input wire logic limiting_thermal_trip,
  input wire logic normal_thermal_trip,
  input wire logic load_above,
  input wire logic load_below,
  output logic switch_on,
  output logic high_limit_setting,
  output logic low_limit_setting,
  output logic discharge_on,
  output logic cs_enable,
  output logic data_bypass,
  output logic auto_switch_en,
  output logic status_n,
  output logic fault_n,
  output logic irq
);
  import cpmc_pkg::*;
  cpmc_mode_e cur_mode;
  cpmc_mode_e mode_req;
  cpmc_st_e st;
  logic [CPMC_CNT_W-1:0] dcnt;
  logic limiting;
  logic trip;
  logic changed;
  logic rep_mode;
  logic status_act;
  logic hi_done;
  logic lo_done;
  logic [31:0] ctrl;
  logic [CPMC_IRQ_W-1:0] irq_stat;
  logic [CPMC_IRQ_W-1:0] irq_mask;
  logic [CPMC_IRQ_W-1:0] ev;
  logic wr;
  logic rd;
  logic disch_end;
  default clocking cpmc_cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // ***************************************************************
  // decode and thermal selection
  // ***************************************************************
  always_comb
  begin
    mode_req = cpmc_decode({mode_select_msb, mode_select_mid,
                            mode_select_lsb});
    limiting = overcurrent && (cur_mode != CPMC_M_CLIENT);
    trip = limiting ? limiting_thermal_trip : normal_thermal_trip;
    changed = (mode_req != cur_mode);
    rep_mode = cpmc_is_high(cur_mode);
    disch_end = (st == CPMC_ST_DISCH) && (dcnt >= CPMC_CNT_W'(DISCH_CYC - 1));
  end

  // ***************************************************************
  // mode and protection state machine
  // ***************************************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st <= CPMC_ST_RUN;
      cur_mode <= CPMC_M_CLIENT;
      dcnt <= '0;
    end
    else
    begin
      case (st)
        CPMC_ST_RUN:
        begin
          if (trip && (cur_mode != CPMC_M_CLIENT))
            st <= CPMC_ST_THERM;
          else if (changed && cpmc_exempt(cur_mode, mode_req))
            cur_mode <= mode_req;
          else if (changed)
          begin
            st <= CPMC_ST_DISCH;
            dcnt <= '0;
          end
        end
        CPMC_ST_DISCH:
        begin
          if (trip && (cur_mode != CPMC_M_CLIENT))
            st <= CPMC_ST_THERM;
          else if (disch_end)
          begin
            cur_mode <= mode_req;
            st <= CPMC_ST_RUN;
          end
          else
            dcnt <= dcnt + CPMC_CNT_W'(1);
        end
        CPMC_ST_THERM:
        begin
          if (!trip)
            st <= CPMC_ST_RUN;
        end
        default: st <= CPMC_ST_RUN;
      endcase
    end
  end

  // ***************************************************************
  // status qualification
  // ***************************************************************
  cpmc_qual #(.COUNT(STATUS_ON_CYC), .W(CPMC_CNT_W)) u_qual_on (
    .pclk(pclk),
    .presetn(presetn),
    .cond(rep_mode && load_above),
    .done(hi_done)
  );

  cpmc_qual #(.COUNT(STATUS_OFF_CYC), .W(CPMC_CNT_W)) u_qual_off (
    .pclk(pclk),
    .presetn(presetn),
    .cond(rep_mode && load_below),
    .done(lo_done)
  );

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      status_act <= 1'b0;
    else if (!rep_mode)
      status_act <= 1'b0;
    else if (hi_done)
      status_act <= 1'b1;
    else if (lo_done)
      status_act <= 1'b0;
  end

  // ***************************************************************
  // registered outputs
  // ***************************************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      switch_on <= 1'b0;
      high_limit_setting <= 1'b0;
      low_limit_setting <= 1'b0;
      discharge_on <= 1'b0;
      cs_enable <= 1'b0;
      data_bypass <= 1'b0;
      auto_switch_en <= 1'b0;
      status_n <= 1'b1;
      fault_n <= 1'b1;
    end
    else
    begin
      switch_on <= (st == CPMC_ST_RUN) && (cur_mode != CPMC_M_CLIENT) &&
                   !ctrl[CPMC_CTRL_SW_OFF];
      high_limit_setting <= cpmc_is_high(cur_mode);
      low_limit_setting <= !cpmc_is_high(cur_mode) &&
                           (cur_mode != CPMC_M_CLIENT);
      discharge_on <= (st == CPMC_ST_DISCH);
      cs_enable <= (cur_mode != CPMC_M_CLIENT);
      data_bypass <= (cur_mode == CPMC_M_CLIENT);
      auto_switch_en <= (cur_mode == CPMC_M_CDP);
      status_n <= !(status_act && rep_mode);
      fault_n <= !((st == CPMC_ST_THERM) ||
                   (overcurrent && (cur_mode != CPMC_M_DCP_LO) &&
                    (cur_mode != CPMC_M_SDP_LO) &&
                    (cur_mode != CPMC_M_CLIENT)));
    end
  end

  // ***************************************************************
  // apb slave and interrupts
  // ***************************************************************
  assign wr = psel && penable && pwrite;
  assign rd = psel && penable && !pwrite;

  always_comb
  begin
    ev = '0;
    ev[CPMC_IRQ_THERM] = (st != CPMC_ST_THERM) &&
                         (cur_mode != CPMC_M_CLIENT) && trip;
    ev[CPMC_IRQ_MODE] = (st == CPMC_ST_RUN) && changed;
    ev[CPMC_IRQ_STATUS] = rep_mode && hi_done && !status_act;
    ev[CPMC_IRQ_DISCH] = disch_end && !trip;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl <= CPMC_CTRL_RST;
      irq_mask <= CPMC_MASK_RST;
    end
    else if (wr && paddr == CPMC_OFS_CTRL)
      ctrl <= {31'h0, pwdata[CPMC_CTRL_SW_OFF]};
    else if (wr && paddr == CPMC_OFS_IRQ_MASK)
      irq_mask <= pwdata[CPMC_IRQ_W-1:0];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_stat <= '0;
    else if (rd && paddr == CPMC_OFS_IRQ_STAT)
      irq_stat <= ev;
    else
      irq_stat <= irq_stat | ev;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq <= 1'b0;
    else
      irq <= |(((rd && paddr == CPMC_OFS_IRQ_STAT) ? ev : (irq_stat | ev)) &
               irq_mask);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= '0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && (paddr != CPMC_OFS_CTRL) &&
                 (paddr != CPMC_OFS_STATE) && (paddr != CPMC_OFS_IRQ_STAT) &&
                 (paddr != CPMC_OFS_IRQ_MASK);
      prdata <= '0;
      if (psel && !penable && !pwrite)
      begin
        case (paddr)
          CPMC_OFS_CTRL: prdata <= ctrl;
          CPMC_OFS_STATE: prdata <= {24'h0, fault_n, switch_on, status_act,
                                     st, cur_mode};
          CPMC_OFS_IRQ_STAT: prdata <= {28'h0, irq_stat | ev};
          CPMC_OFS_IRQ_MASK: prdata <= {28'h0, irq_mask};
          default: prdata <= '0;
        endcase
      end
    end
  end

  // ***************************************************************
  // checks
  // ***************************************************************
  sequence s_disch_enter;
    (st == CPMC_ST_RUN) && changed && !cpmc_exempt(cur_mode, mode_req) &&
    !(trip && cur_mode != CPMC_M_CLIENT);
  endsequence

  sequence s_disch_hold;
    (st == CPMC_ST_DISCH) ##1 (discharge_on && !switch_on);
  endsequence

  AST_DISCH_ENTRY: assert property (
    s_disch_enter |=> s_disch_hold)
    else $error("discharge not entered on mode change");

  AST_EXEMPT: assert property (
    (st == CPMC_ST_RUN) && changed && cpmc_exempt(cur_mode, mode_req) &&
    !trip |=> (st == CPMC_ST_RUN) && (cur_mode == $past(mode_req)))
    else $error("exempt change did not switch directly");

  AST_HI_LIMIT: assert property (
    cpmc_is_high(cur_mode) |=> high_limit_setting && !low_limit_setting)
    else $error("wrong limit in high mode");

  AST_STATUS_OFF: assert property (
    !rep_mode |=> ##1 status_n)
    else $error("status asserted in non reporting mode");

  AST_CLIENT: assert property (
    (cur_mode == CPMC_M_CLIENT) && !overcurrent |=> !switch_on &&
    data_bypass && !cs_enable && fault_n && status_n)
    else $error("client mode outputs wrong");

  AST_THERM_OFF: assert property (
    (st == CPMC_ST_THERM) |=> !switch_on && !fault_n)
    else $error("switch on or fault clear in shutdown");

  AST_LIMIT_TRIP: assert property (
    (st == CPMC_ST_RUN) && limiting && limiting_thermal_trip
    |=> (st == CPMC_ST_THERM))
    else $error("limiting trip ignored");

  AST_RESTART: assert property (
    (st == CPMC_ST_THERM) && !trip |=> (st == CPMC_ST_RUN))
    else $error("no restart after trip cleared");

  AST_OC_NOFAULT: assert property (
    (st == CPMC_ST_RUN) && !trip && ((cur_mode == CPMC_M_DCP_LO) ||
    (cur_mode == CPMC_M_SDP_LO)) |=> fault_n)
    else $error("overcurrent fault in low limit mode");

  AST_AUTO: assert property (
    $changed(cur_mode) |=> (auto_switch_en == ($past(cur_mode) == CPMC_M_CDP)))
    else $error("auto switch enable wrong");

endmodule

/* sim/charging_port_mode_control_tb.sv */
// self-checking bench for the charging port mode control
`timescale 1ns/1ps
module charging_port_mode_control_tb;
  import cpmc_pkg::*;
  // ***************************************************************
  // stimulus, scoreboard and checks
  // ***************************************************************
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic msb, mid, lsb, ovc, ltrip, ntrip, above, below;
  logic switch_on, hi, lo, discharge_on, cs, byp, auto, status_n, fault_n;
  logic irq, ppm_en, peer_n;
  logic [2:0] req;
  logic [7:0] outs;
  logic [64:0] notes[$];
  logic [64:0] nt;
  int bad_count, total_checks, cyc, i;
  integer seed;
  assign outs = {switch_on, hi, lo, cs, byp, auto, status_n, fault_n};
  cpmc_top #(.STATUS_ON_CYC(8), .STATUS_OFF_CYC(12), .DISCH_CYC(5)) uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .mode_select_msb(msb),
    .mode_select_mid(mid), .mode_select_lsb(lsb), .overcurrent(ovc),
    .limiting_thermal_trip(ltrip), .normal_thermal_trip(ntrip),
    .load_above(above), .load_below(below), .switch_on(switch_on),
    .high_limit_setting(hi), .low_limit_setting(lo),
    .discharge_on(discharge_on), .cs_enable(cs), .data_bypass(byp),
    .auto_switch_en(auto), .status_n(status_n), .fault_n(fault_n),
    .irq(irq));
  cpmc_ctl_model ctl (
    .pclk(pclk), .presetn(presetn), .req_mode(req), .ppm_en(ppm_en),
    .peer_status_n(peer_n), .status_n(status_n), .mode_select_msb(msb),
    .mode_select_mid(mid), .mode_select_lsb(lsb));
  initial
  begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
                     input string what);
    total_checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [31:0] m, input logic [31:0] e,
                     input logic err);
    notes.push_back({err, m, e});
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] m,
                    input logic [31:0] e);
    apb(1'b0, a, 32'h0, m, e, 1'b0);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 32'h0, 32'h0, 1'b0);
  endtask
  function automatic logic [2:0] cm(input logic [2:0] p);
    return (p == 3'h3 || p == 3'h5) ? p - 3'h1 : p;
  endfunction
  function automatic logic [7:0] ex(input logic [2:0] p);
    logic cl;
    cl = (p[2:1] == 2'b10);
    return {!cl, p == 3'h1 || p == 3'h7, p == 3'h0 || p[2:1] == 2'b01 ||
            p == 3'h6, !cl, cl, p == 3'h7, 2'b11};
  endfunction
  task automatic step(input logic [2:0] p);
    logic [2:0] was;
    logic dis;
    was = req;
    dis = 1'b0;
    @(posedge pclk);
    req <= p;
    repeat (16)
    begin
      @(posedge pclk);
      dis = dis | discharge_on;
      if (discharge_on === 1'b1)
        chk(switch_on, 32'h0, "switch_on in discharge");
    end
    if (cm(was) !== cm(p))
      chk(dis, !((was ^ p) == 3'h1 && was[2] == was[1]),
          "discharge_on");
    chk(outs, ex(p), "mode outputs");
    rd(CPMC_OFS_STATE, 32'hff, {24'h0, 1'b1, p[2:1] != 2'b10, 3'h0,
       cm(p)});
  endtask
  always @(posedge pclk)
  begin
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1)
    begin
      if (notes.size() == 0)
        chk(1'b1, 1'b0, "unexpected transfer");
      else
      begin
        nt = notes.pop_front();
        chk(prdata & nt[63:32], nt[31:0] & nt[63:32], "prdata");
        chk(pslverr, nt[64], "pslverr");
      end
    end
  end
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      bad_count++;
      end_sim();
    end
  end
  initial
  begin
    seed = 32'h484677c6;
    presetn = 1'b0;
    {psel, penable, pwrite, ovc, ltrip, ntrip, above, below, ppm_en} = 9'h0;
    paddr = 8'h0;
    pwdata = 32'h0;
    req = 3'h4;
    peer_n = 1'b1;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    rd(CPMC_OFS_CTRL, 32'hffffffff, CPMC_CTRL_RST);
    rd(CPMC_OFS_IRQ_MASK, 32'hf, {28'h0, CPMC_MASK_RST});
    rd(CPMC_OFS_STATE, 32'hff, 32'h84);
    apb(1'b0, 8'h10, 32'h0, 32'hffffffff, 32'h0, 1'b1);
    wr(CPMC_OFS_IRQ_MASK, 32'h1);
    for (i = 0; i < 8; i++)
      step(i[2:0]);
    for (i = 0; i < 6; i++)
      step(3'($random(seed)));
    step(3'h1);
    wr(CPMC_OFS_CTRL, 32'h1);
    repeat (3) @(posedge pclk);
    chk(switch_on, 32'h0, "switch_on forced off");
    wr(CPMC_OFS_CTRL, 32'h0);
    repeat (3) @(posedge pclk);
    chk(switch_on, 32'h1, "switch_on restored");
    above <= 1'b1;
    repeat (5) @(posedge pclk);
    chk(status_n, 32'h1, "status_n early");
    repeat (12) @(posedge pclk);
    chk(status_n, 32'h0, "status_n set");
    above <= 1'b0;
    below <= 1'b1;
    repeat (8) @(posedge pclk);
    chk(status_n, 32'h0, "status_n held");
    repeat (12) @(posedge pclk);
    chk(status_n, 32'h1, "status_n cleared");
    below <= 1'b0;
    step(3'h0);
    above <= 1'b1;
    ovc <= 1'b1;
    repeat (20) @(posedge pclk);
    chk({status_n, fault_n, switch_on}, 32'h7,
        "flags in 000");
    above <= 1'b0;
    req <= 3'h1;
    repeat (16) @(posedge pclk);
    chk({fault_n, switch_on}, 32'h1, "overcurrent in 001");
    ntrip <= 1'b1;
    repeat (4) @(posedge pclk);
    chk(switch_on, 32'h1, "normal trip while limiting");
    ltrip <= 1'b1;
    repeat (4) @(posedge pclk);
    chk({switch_on, fault_n, irq}, 32'h1, "thermal off");
    req <= 3'h0;
    repeat (16) @(posedge pclk);
    chk({switch_on, fault_n}, 32'h0, "thermal holds");
    rd(CPMC_OFS_IRQ_STAT, 32'h1, 32'h1);
    repeat (2) @(posedge pclk);
    chk(irq, 32'h0, "irq after read");
    {ovc, ltrip, ntrip} <= 3'h0;
    repeat (20) @(posedge pclk);
    chk({switch_on, fault_n}, 32'h3, "restart");
    ntrip <= 1'b1;
    repeat (4) @(posedge pclk);
    chk({switch_on, fault_n}, 32'h0, "normal trip");
    ntrip <= 1'b0;
    repeat (4) @(posedge pclk);
    chk(switch_on, 32'h1, "second restart");
    step(3'h7);
    ppm_en <= 1'b1;
    peer_n <= 1'b0;
    repeat (16) @(posedge pclk);
    chk(outs, ex(3'h6), "shed to 110");
    peer_n <= 1'b1;
    repeat (16) @(posedge pclk);
    chk(outs, ex(3'h7), "back to 111");
    end_sim();
  end
endmodule

/* sim/cpmc_ctl_model.sv */
// system controller model: drives the mode pins, sheds load on peer status
`timescale 1ns/1ps
module cpmc_ctl_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [2:0] req_mode,
  input wire logic ppm_en,
  input wire logic peer_status_n,
  input wire logic status_n,
  output logic mode_select_msb,
  output logic mode_select_mid,
  output logic mode_select_lsb
);
  // ***************************************************************
  // port power management
  // ***************************************************************
  logic [2:0] pins;
  logic shed;
  assign shed = ppm_en && !peer_status_n && status_n;
  assign {mode_select_msb, mode_select_mid, mode_select_lsb} = pins;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pins <= 3'h4;
    else if (shed && (req_mode == 3'h7 || req_mode == 3'h1))
      pins <= {req_mode[2:1], 1'b0};
    else
      pins <= req_mode;
  end
endmodule
